/* design/uft_consts.svh */
`ifndef UFT_CONSTS_SVH
`define UFT_CONSTS_SVH

// Register offsets on the software port.
`define UFT_OFF_STATUS 3'h0
`define UFT_OFF_FORMAT 3'h1
`define UFT_OFF_DIRECTION 3'h2
`define UFT_OFF_SINGLE_LINE 3'h3
`define UFT_OFF_DATA 3'h4
`define UFT_OFF_BAUD 3'h5

// Format control register fields.
`define UFT_FMT_PORT_EN 7
`define UFT_FMT_WORD9 6
`define UFT_FMT_PARITY_ON 5
`define UFT_FMT_PARITY_ODD 4
`define UFT_FMT_STOP2 3
`define UFT_FMT_NINTH_TX 0
`define UFT_FMT_WR_MASK 8'hF9

// Direction control register fields.
`define UFT_DIR_TX_EN 7
`define UFT_DIR_RX_EN 6
`define UFT_DIR_BREAK 5
`define UFT_DIR_ADDR_DET 4
`define UFT_DIR_HIGH_SPEED 3
`define UFT_DIR_RX_IE 2
`define UFT_DIR_IDLE_IE 1
`define UFT_DIR_READY_IE 0
`define UFT_DIR_KEEP_MASK 8'h1F

// Port status register fields.
`define UFT_STS_TX_READY 0
`define UFT_STS_TX_IDLE 1
`define UFT_STS_RX_READY 2
`define UFT_STS_RX_IDLE 3

// Reset values: eight data bits, no parity, one stop bit, port off.
`define UFT_FMT_RST 8'h00
`define UFT_DIR_RST 8'h00
`define UFT_BAUD_RST 8'h00
`define UFT_SWM_RST 1'h0
`define UFT_READ_IDLE 8'h00

// Baud prescaler limits and frame bit counts.
`define UFT_PRESC_LOW 6'h3F
`define UFT_PRESC_HIGH 6'h0F
`define UFT_BITS_8 4'h8
`define UFT_BITS_9 4'h9
`define UFT_BITS_BREAK 4'hD

`endif

/* design/uft_pkg.sv */
package uft_pkg;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_WAIT  = 5'h02,
      TX_START = 5'h04,
      TX_DATA  = 5'h08,
      TX_STOP  = 5'h10
   } uft_tx_state_type;

endpackage : uft_pkg

/* design/uft_baud.sv */
`timescale 1ns/10ps
`include "uft_consts.svh"

module uft_baud (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic high_speed,
   input wire logic [7:0] divisor,
   output logic baud_tick
);
   logic [5:0] presc_ff;
   logic [7:0] div_ff;
   logic presc_wrap;
   logic div_wrap;

   assign presc_wrap = presc_ff >= (high_speed ? `UFT_PRESC_HIGH : `UFT_PRESC_LOW);
   // A divisor lowered below the running count must not cost a full 256-step wrap.
   assign div_wrap = div_ff >= divisor;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         presc_ff <= 6'h00;
         div_ff <= 8'h00;
      end else if (!run) begin
         presc_ff <= 6'h00;
         div_ff <= 8'h00;
      end else if (presc_wrap) begin
         presc_ff <= 6'h00;
         div_ff <= div_wrap ? 8'h00 : div_ff + 8'h01;
      end else begin
         presc_ff <= presc_ff + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= run && presc_wrap && div_wrap; // see [R23]
      end
   end

endmodule : uft_baud

/* design/uft_frame_build.sv */
`timescale 1ns/10ps

module uft_frame_build (
   input wire logic [7:0] data,
   input wire logic ninth,
   input wire logic word9,
   input wire logic parity_on,
   input wire logic parity_odd,
   output logic [8:0] word
);
   logic parity;

   always_comb begin
      word = {word9 & ninth, data}; // see [R12]
      parity = word9 ? ^data : ^data[6:0]; // see [R24]
      parity = parity ^ parity_odd;
      if (parity_on) begin // see [R2]
         // The top position of the word carries parity instead of data.
         if (word9) begin
            word[8] = parity; // see [R10]
         end else begin
            word[7] = parity; // see [R10]
         end
      end
   end

endmodule : uft_frame_build

/* design/uft_top.sv */
// Summary of operation
// [R1] Frames are NRZ: start bit, eight or nine data bits, one or two stop bits.
// [R2] Even, odd or no parity is selectable for both directions.
// [R3] Power-on format is eight data bits, no parity, one stop bit.
// [R4] Bits go out LSB first; both directions share format and 8-bit baud generator.
// [R5] With port, transmit and receive enabled, pins serve as serial out/in; idle high.
// [R6] Clearing port enable releases both serial pins to other functions.
// [R7] Disable empties buffer, clears enables, break, receive flags; sets idle and ready flags.
// [R8] Disabling aborts activity at once; re-enable resumes with preserved configuration.
// [R9] Word length, parity polarity, parity on/off and stop count set the format.
// [R10] The top word position carries parity or the address flag.
// [R11] Two stop bits apply to transmit only; receiver checks one stop bit.
// [R12] In nine-bit mode the ninth transmit bit comes from a control bit.
// [R13] Shift register reloads only after the stop bit and only when data waits.
// [R14] A frame starts with enable, loaded data and baud ticks, in either order.
// [R15] Clearing transmit enable stops output at once and releases the pin.
// [R16] Data writes are ignored while the transmit-ready flag is low.
// [R17] Status access followed by data write clears the transmit-ready flag.
// [R18] Hardware sets transmit-ready when holding is empty; it requests an interrupt if enabled.
// [R19] A write during a frame waits in holding until the frame ends.
// [R20] A write while idle loads the shifter directly and leaves transmit-ready set.
// [R21] Transmit-idle is set when a frame or break frame finishes.
// [R22] Transmit-idle clears by the same status-then-data-write pair.
// [R23] Baud rate is clock over 64(N+1) low speed or 16(N+1) high speed.
// [R24] The parity bit makes the count of ones match the chosen polarity.
`timescale 1ns/10ps
`include "uft_consts.svh"

module uft_top
   import uft_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic tx_out,
   output logic tx_oe_n,
   output logic rx_claim,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////////////
   logic [7:0] fmt_ff;
   logic [7:0] dir_ff;
   logic [7:0] baud_ff;
   logic swm_ff;
   logic [7:0] hold_ff;
   logic hold_full_ff;
   logic transmit_ready_flag_ff;
   logic transmit_idle_flag_ff;
   logic armed_ff;
   logic [7:0] rdata_ff;
   logic irq_ff;
   uft_tx_state_type state_ff;
   logic [8:0] shreg_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nbits_ff;
   logic brk_ff;
   logic stop2_ff;
   logic txd_ff;
   logic done_ff;

   logic port_enable;
   logic transmit_enable;
   logic break_request;
   logic word9;
   logic tx_run;
   logic baud_tick;
   logic wr_data;
   logic accept;
   logic sh_idle;
   logic direct;
   logic start_load;
   logic start_brk;
   logic clr_pair;
   logic nxt_hold_full;
   logic last_stop;
   logic [8:0] frame_word;
   logic [7:0] status_val;

   assign port_enable = fmt_ff[`UFT_FMT_PORT_EN];
   assign transmit_enable = dir_ff[`UFT_DIR_TX_EN];
   assign break_request = dir_ff[`UFT_DIR_BREAK];
   assign word9 = fmt_ff[`UFT_FMT_WORD9];
   assign tx_run = port_enable && transmit_enable;
   assign sh_idle = state_ff == TX_IDLE;

   ////////////////////////////////////////////////////////////////////////////////////////
   uft_baud u_baud (
      .clk(clk),
      .resetn(resetn),
      .run(port_enable),
      .high_speed(dir_ff[`UFT_DIR_HIGH_SPEED]),
      .divisor(baud_ff),
      .baud_tick(baud_tick)
   );

   // The builder sees the held byte when one waits, else the byte being written now.
   uft_frame_build u_frame (
      .data(hold_full_ff ? hold_ff : reg_wdata),
      .ninth(fmt_ff[`UFT_FMT_NINTH_TX]),
      .word9(word9),
      .parity_on(fmt_ff[`UFT_FMT_PARITY_ON]),
      .parity_odd(fmt_ff[`UFT_FMT_PARITY_ODD]),
      .word(frame_word)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fmt_ff <= `UFT_FMT_RST; // see [R3]
      end else if (reg_wr && reg_addr == `UFT_OFF_FORMAT) begin
         fmt_ff <= reg_wdata & `UFT_FMT_WR_MASK; // see [R9]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dir_ff <= `UFT_DIR_RST;
      end else if (!port_enable) begin
         // Enables and break stay clear while the port is off; other bits survive.
         if (reg_wr && reg_addr == `UFT_OFF_DIRECTION) begin
            dir_ff <= reg_wdata & `UFT_DIR_KEEP_MASK; // see [R7]
         end else begin
            dir_ff <= dir_ff & `UFT_DIR_KEEP_MASK; // see [R7]
         end
      end else if (reg_wr && reg_addr == `UFT_OFF_DIRECTION) begin
         dir_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baud_ff <= `UFT_BAUD_RST;
      end else if (reg_wr && reg_addr == `UFT_OFF_BAUD) begin
         baud_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         swm_ff <= `UFT_SWM_RST;
      end else if (reg_wr && reg_addr == `UFT_OFF_SINGLE_LINE) begin
         swm_ff <= reg_wdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Software access sequencing and the holding register.

   assign wr_data = reg_wr && reg_addr == `UFT_OFF_DATA;
   assign accept = wr_data && transmit_ready_flag_ff; // see [R16]
   assign clr_pair = accept && armed_ff; // see [R17]
   // A frame in progress or a byte already waiting sends the new byte to holding.
   assign direct = accept && tx_run && sh_idle && !hold_full_ff && !break_request; // see [R20]
   assign start_load = tx_run && sh_idle && (direct || hold_full_ff); // see [R13]
   assign start_brk = tx_run && sh_idle && !start_load && break_request;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         armed_ff <= 1'b0;
      end else if (wr_data) begin
         armed_ff <= 1'b0;
      end else if ((reg_rd || reg_wr) && reg_addr == `UFT_OFF_STATUS) begin
         armed_ff <= 1'b1;
      end
   end

   always_comb begin
      nxt_hold_full = hold_full_ff;
      if (!port_enable) begin
         nxt_hold_full = 1'b0; // see [R7]
      end else if (accept && !direct) begin
         nxt_hold_full = 1'b1; // see [R19]
      end else if (start_load) begin
         nxt_hold_full = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_full_ff <= 1'b0;
      end else begin
         hold_full_ff <= nxt_hold_full;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_ff <= 8'h00;
      end else if (port_enable && accept && !direct) begin
         hold_ff <= reg_wdata;
      end
   end

   // Hardware set wins over the software clear arriving in the same cycle.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         transmit_ready_flag_ff <= 1'b1;
      end else begin
         transmit_ready_flag_ff <= (transmit_ready_flag_ff && !clr_pair) || !nxt_hold_full; // see [R18]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         transmit_idle_flag_ff <= 1'b1;
      end else begin
         transmit_idle_flag_ff <= (transmit_idle_flag_ff && !clr_pair) || done_ff || !port_enable; // see [R21] [R22]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Transmit engine. Each bit lasts one baud tick period; WAIT aligns to the tick grid.

   assign last_stop = state_ff == TX_STOP && baud_tick && !(stop2_ff && cnt_ff == 4'h0);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= TX_IDLE;
         shreg_ff <= 9'h000;
         cnt_ff <= 4'h0;
         nbits_ff <= `UFT_BITS_8;
         brk_ff <= 1'b0;
         stop2_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else if (!tx_run) begin
         state_ff <= TX_IDLE; // see [R8] [R15]
         cnt_ff <= 4'h0;
         brk_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         unique case (state_ff)
            TX_IDLE: begin
               txd_ff <= 1'b1; // see [R5]
               if (start_load) begin
                  shreg_ff <= frame_word;
                  nbits_ff <= word9 ? `UFT_BITS_9 : `UFT_BITS_8; // see [R1]
                  stop2_ff <= fmt_ff[`UFT_FMT_STOP2]; // see [R11]
                  brk_ff <= 1'b0;
                  state_ff <= TX_WAIT; // see [R14]
               end else if (start_brk) begin
                  shreg_ff <= 9'h000;
                  nbits_ff <= `UFT_BITS_BREAK;
                  stop2_ff <= fmt_ff[`UFT_FMT_STOP2];
                  brk_ff <= 1'b1;
                  state_ff <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (baud_tick) begin
                  txd_ff <= 1'b0; // see [R1]
                  state_ff <= TX_START;
               end
            end
            TX_START: begin
               if (baud_tick) begin
                  txd_ff <= shreg_ff[0]; // see [R4]
                  shreg_ff <= {1'b0, shreg_ff[8:1]};
                  cnt_ff <= 4'h1;
                  state_ff <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (baud_tick) begin
                  if (cnt_ff != nbits_ff) begin
                     txd_ff <= brk_ff ? 1'b0 : shreg_ff[0]; // see [R4]
                     shreg_ff <= {1'b0, shreg_ff[8:1]};
                     cnt_ff <= cnt_ff + 4'h1;
                  end else if (brk_ff && break_request) begin
                     // A held break request repeats break characters back to back.
                     txd_ff <= 1'b0;
                     cnt_ff <= 4'h1;
                  end else begin
                     txd_ff <= 1'b1;
                     cnt_ff <= 4'h0;
                     state_ff <= TX_STOP;
                  end
               end
            end
            TX_STOP: begin
               if (baud_tick) begin
                  txd_ff <= 1'b1;
                  if (last_stop) begin
                     state_ff <= TX_IDLE; // see [R13]
                  end else begin
                     cnt_ff <= 4'h1; // see [R11]
                  end
               end
            end
            default: begin
               state_ff <= TX_IDLE;
               txd_ff <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= tx_run && last_stop; // see [R21]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read port and pin ownership. No receiver sits here, so receive flags read idle.

   always_comb begin
      status_val = 8'h00;
      status_val[`UFT_STS_TX_READY] = transmit_ready_flag_ff;
      status_val[`UFT_STS_TX_IDLE] = transmit_idle_flag_ff;
      status_val[`UFT_STS_RX_IDLE] = 1'b1; // see [R7]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= `UFT_READ_IDLE;
      end else if (!reg_rd) begin
         rdata_ff <= `UFT_READ_IDLE;
      end else begin
         unique case (reg_addr)
            `UFT_OFF_STATUS: rdata_ff <= status_val;
            `UFT_OFF_FORMAT: rdata_ff <= fmt_ff;
            `UFT_OFF_DIRECTION: rdata_ff <= dir_ff;
            `UFT_OFF_SINGLE_LINE: rdata_ff <= {7'h00, swm_ff};
            `UFT_OFF_BAUD: rdata_ff <= baud_ff;
            default: rdata_ff <= `UFT_READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (transmit_ready_flag_ff && dir_ff[`UFT_DIR_READY_IE]) || // see [R18]
                   (transmit_idle_flag_ff && dir_ff[`UFT_DIR_IDLE_IE]);
      end
   end

   assign reg_rdata = rdata_ff;
   assign tx_out = txd_ff;
   assign tx_oe_n = !tx_run; // see [R6] [R15]
   assign rx_claim = port_enable && dir_ff[`UFT_DIR_RX_EN]; // see [R5] [R6]
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_status_then_write;
      armed_ff && accept && port_enable && !direct && !done_ff;
   endsequence

   sequence s_quiet_tick;
      baud_tick && dir_ff[`UFT_DIR_HIGH_SPEED] && baud_ff == 8'h00 && !reg_wr;
   endsequence

   a_idle_line_high: assert property ( // see [R5]
      sh_idle && tx_run |-> txd_ff)
      else $error("transmit line not high while idle");

   a_write_ignored: assert property ( // see [R16]
      wr_data && !transmit_ready_flag_ff |=> hold_ff == $past(hold_ff) && sh_idle == $past(sh_idle && !start_load && !start_brk) || !sh_idle)
      else $error("data write taken while transmit-ready low");

   a_disable_flags: assert property ( // see [R7]
      !port_enable |=> transmit_ready_flag_ff && transmit_idle_flag_ff && !hold_full_ff && !dir_ff[`UFT_DIR_TX_EN])
      else $error("disable did not reset flags");

   a_abort_frame: assert property ( // see [R8]
      !tx_run |=> sh_idle && txd_ff && cnt_ff == 4'h0)
      else $error("frame not aborted on disable");

   a_clear_pair: assert property ( // see [R17]
      s_status_then_write |=> !transmit_ready_flag_ff && !transmit_idle_flag_ff)
      else $error("clear sequence did not clear flags");

   a_direct_load: assert property ( // see [R20]
      direct |=> state_ff == TX_WAIT && transmit_ready_flag_ff && !hold_full_ff)
      else $error("idle write did not load shifter directly");

   a_start_low: assert property ( // see [R1]
      state_ff == TX_START |-> !txd_ff)
      else $error("start bit not low");

   a_lsb_first: assert property ( // see [R4]
      state_ff == TX_START && baud_tick && !reg_wr |=> txd_ff == $past(shreg_ff[0]))
      else $error("first data bit is not the lsb");

   a_stop_reload: assert property ( // see [R13]
      state_ff == TX_STOP |=> state_ff == TX_STOP || sh_idle)
      else $error("shifter left stop early");

   a_baud_gap: assert property ( // see [R23]
      s_quiet_tick |=> !baud_tick [*8])
      else $error("baud tick too early in high speed mode");

endmodule : uft_top

/* dv/uft_remote_rx.sv */
`timescale 1ns/10ps

// Far-end receiver. It samples each bit in its middle, as a real receiver does.
module uft_remote_rx (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tx_out,
   input wire logic tx_oe_n,
   input wire logic [3:0] data_bits,
   input wire logic two_stop,
   input wire logic [7:0] bit_cycles,
   output logic frame_seen,
   output logic [8:0] frame_word,
   output logic stop_ok
);
   logic line;
   logic good;
   logic stop_hi;
   logic [8:0] w;

   // A released pin is pulled up, so an aborted frame looks like an idle line.
   assign line = tx_oe_n ? 1'b1 : tx_out;

   task automatic hold(input int n);
      repeat (n) begin
         @(posedge clk);
         if (tx_oe_n || !resetn) good = 1'b0;
      end
   endtask : hold

   initial begin
      frame_seen = 1'b0;
      frame_word = 9'h000;
      stop_ok = 1'b0;
      forever begin
         @(posedge clk);
         frame_seen <= 1'b0;
         if (resetn && !line) begin
            good = 1'b1;
            w = 9'h000;
            hold(bit_cycles / 2);
            good = good & !line;
            for (int i = 0; i < data_bits; i++) begin
               hold(bit_cycles);
               w[i] = line;
            end
            hold(bit_cycles);
            stop_hi = line;
            if (two_stop) begin
               hold(bit_cycles);
               stop_hi = stop_hi & line;
            end
            if (good) begin
               frame_word <= w;
               stop_ok <= stop_hi;
               frame_seen <= 1'b1;
            end
         end
      end
   end
endmodule : uft_remote_rx

/* dv/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
   logic clk, resetn, reg_wr, reg_rd, tx_out, tx_oe_n, rx_claim, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, bit_cycles;
   logic [3:0] data_bits;
   logic two_stop, frame_seen, stop_ok, rd_pend;
   logic [8:0] frame_word;
   logic [15:0] seed;
   logic [7:0] d [3];
   logic [15:0] rq [$];
   logic [9:0] fq [$];
   int failures, checks;
   logic [7:0] fmt_t [6] = '{8'h80, 8'hA0, 8'hB0, 8'hC1, 8'hE8, 8'h80};
   logic [7:0] dir_t [6] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h88, 8'h80};
   logic [7:0] baud_t [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   logic [7:0] bc_t [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h80};

   uft_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_out(tx_out),
      .tx_oe_n(tx_oe_n), .rx_claim(rx_claim), .irq(irq));

   uft_remote_rx u_far (.clk(clk), .resetn(resetn), .tx_out(tx_out), .tx_oe_n(tx_oe_n),
      .data_bits(data_bits), .two_stop(two_stop), .bit_cycles(bit_cycles),
      .frame_seen(frame_seen), .frame_word(frame_word), .stop_ok(stop_ok));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   // Frame word in line order; the top position holds parity or the ninth bit.
   function automatic logic [8:0] exp_word(input logic [7:0] v, input logic [7:0] f);
      logic [8:0] w;
      w = {f[0] & f[6], v};
      if (f[5] && !f[6]) w[7] = ^v[6:0] ^ f[4];
      if (f[5] && f[6]) w[8] = ^v ^ f[4];
      return w;
   endfunction : exp_word

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic check_read(input logic [7:0] exp, input logic [7:0] got);
      check("read data", 10'(exp), 10'(got));
   endtask : check_read

   task automatic check_frame(input logic [9:0] exp, input logic [9:0] got);
      check("serial frame", exp, got);
   endtask : check_frame

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // A zero mask still queues the read, but its result is not checked.
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back({mask, exp});
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic pair_wr(input logic [7:0] v);
      rd(3'h0, 8'h00, 8'h00);
      wr(3'h4, v);
   endtask : pair_wr

   task automatic wait_drain();
      for (int n = 0; n < 8000 && fq.size() > 0; n++) @(posedge clk);
      if (fq.size() > 0) begin
         failures++;
         $display("CHECK FAILED frames pending expected 0 seen %0d", fq.size());
         finish_test();
      end
   endtask : wait_drain

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin : watch
      logic [15:0] e;
      logic [9:0] f;
      if (rd_pend && rq.size() > 0) begin
         e = rq.pop_front();
         if (e[15:8] != 8'h00) check_read(e[7:0], reg_rdata & e[15:8]);
      end
      rd_pend <= reg_rd;
      if (frame_seen) begin
         f = fq.size() > 0 ? fq.pop_front() : 10'bx;
         check_frame(f, {stop_ok, frame_word});
      end
   end

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      rd_pend = 1'b0;
      data_bits = 4'h8;
      two_stop = 1'b0;
      bit_cycles = 8'h10;
      seed = 16'hA94C;
      failures = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(3'h0, 8'h0B, 8'hFF);
      rd(3'h1, 8'h00, 8'hFF);
      rd(3'h2, 8'h00, 8'hFF);
      rd(3'h7, 8'h00, 8'hFF);
      $display("test reset values done");
      for (int k = 0; k < 6; k++) begin
         wr(3'h5, baud_t[k]);
         // The port goes on first: enables written while it is off are dropped.
         wr(3'h1, fmt_t[k]);
         wr(3'h2, dir_t[k]);
         data_bits <= fmt_t[k][6] ? 4'h9 : 4'h8;
         two_stop <= fmt_t[k][3];
         bit_cycles <= bc_t[k];
         for (int j = 0; j < 3; j++) begin
            seed = lfsr(seed);
            d[j] = seed[7:0];
         end
         fq.push_back({1'b1, exp_word(d[0], fmt_t[k])});
         fq.push_back({1'b1, exp_word(d[1], fmt_t[k])});
         pair_wr(d[0]);
         rd(3'h0, 8'h01, 8'h03);
         pair_wr(d[1]);
         rd(3'h0, 8'h00, 8'h01);
         wr(3'h4, d[2]);
         wait_drain();
         repeat (bc_t[k]) @(posedge clk);
         rd(3'h0, 8'h03, 8'h03);
         $display("test format %0d done", k);
      end
      wr(3'h5, 8'h00);
      wr(3'h2, 8'h89);
      repeat (3) @(posedge clk);
      check("irq", 10'h1, 10'(irq));
      wr(3'h2, 8'h88);
      wr(3'h1, 8'h80);
      data_bits <= 4'h8;
      two_stop <= 1'b0;
      bit_cycles <= 8'h10;
      repeat (3) @(posedge clk);
      check("irq", 10'h0, 10'(irq));
      $display("test interrupt done");
      // Abort by transmit enable: the far end must see the pin released at once.
      pair_wr(8'h00);
      repeat (48) @(posedge clk);
      wr(3'h2, 8'h08);
      repeat (2) @(posedge clk);
      check("tx line", 10'h1, 10'(tx_out));
      check("tx enable n", 10'h1, 10'(tx_oe_n));
      // The far end still times the cut frame; let it finish before the next start bit.
      repeat (160) @(posedge clk);
      wr(3'h2, 8'hC8);
      repeat (2) @(posedge clk);
      check("rx claim", 10'h1, 10'(rx_claim));
      check("tx enable n", 10'h0, 10'(tx_oe_n));
      pair_wr(8'h00);
      pair_wr(8'h55);
      repeat (48) @(posedge clk);
      wr(3'h1, 8'h00);
      repeat (2) @(posedge clk);
      check("tx enable n", 10'h1, 10'(tx_oe_n));
      check("rx claim", 10'h0, 10'(rx_claim));
      rd(3'h2, 8'h08, 8'hFF);
      rd(3'h0, 8'h0B, 8'hFF);
      repeat (160) @(posedge clk);
      // The byte left in holding must not surface after re-enable.
      wr(3'h1, 8'h80);
      wr(3'h2, 8'h88);
      fq.push_back({1'b1, 9'h0A5});
      pair_wr(8'hA5);
      wait_drain();
      repeat (400) @(posedge clk);
      $display("test disable and abort done");
      finish_test();
   end
endmodule : tb_top
